// >>> hw/rtps_cfg.svh
`ifndef RTPS_CFG_SVH
`define RTPS_CFG_SVH

// ----------------------------------------------------------------
// crate bus function and subaddress codes
// ----------------------------------------------------------------
`define RTPS_F_READ_FIFO   5'h00
`define RTPS_F_READ_REG    5'h01
`define RTPS_F_WRITE_FIFO  5'h10
`define RTPS_F_WRITE_REG   5'h11
`define RTPS_A_CTRL        4'h0
`define RTPS_A_MODE        4'h1
`define RTPS_A_STATUS_B    4'h2
`define RTPS_A_STATUS_IN   4'h4
`define RTPS_A_CAP_LOW     4'h0
`define RTPS_A_CAP_HIGH    4'h1
`define RTPS_A_OUT_FIFO    4'h0

// ----------------------------------------------------------------
// mode register fields and reset values
// ----------------------------------------------------------------
`define RTPS_MODE_IN_LSB   0
`define RTPS_MODE_SO_LSB   4
`define RTPS_MODE_FO_LSB   8
`define RTPS_MODE_ID_LSB   16
`define RTPS_MODE_RESET    24'h000000
`define RTPS_CTRL_RESET    4'h0

`define RTPS_IN_OFF        4'h0
`define RTPS_IN_PERMITS    4'h2
`define RTPS_SO_OFF        4'h0
`define RTPS_SO_PERM       4'h1
`define RTPS_SO_RAW        4'h2
`define RTPS_SO_TRIG       4'h3
`define RTPS_FO_OFF        4'h0
`define RTPS_FO_RUN        4'h1
`define RTPS_FO_TRIG       4'h2

// ----------------------------------------------------------------
// buffer geometry
// ----------------------------------------------------------------
`define RTPS_FO_WIDTH      18
`define RTPS_FO_ABITS      13
`define RTPS_CF_WIDTH      32
`define RTPS_CF_ABITS      13
`define RTPS_CF_HALF       14'h1000
`define RTPS_FO_HALF       14'h1000
`define RTPS_FO_PASS_BIT   16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTPS_CLK_NS        25
`define RTPS_PERMIT_MIN_NS 150
`define RTPS_PERMIT_MAX_NS 250
`define RTPS_PERMIT_CYC    ((`RTPS_PERMIT_MIN_NS + `RTPS_CLK_NS - 1) / `RTPS_CLK_NS)
`define RTPS_RAW_SAMPLE_NS 400
`define RTPS_RAW_CYC       ((2 * `RTPS_RAW_SAMPLE_NS + `RTPS_CLK_NS - 1) / `RTPS_CLK_NS)
`define RTPS_STRB_CYC      2
`define RTPS_SYNC_WIDTH    77

`endif

// >>> hw/rtps_pkg.sv
package rtps_pkg;

	// readout sequencer; the third state is the one that frees the trigger latch
	typedef enum logic [2:0] {
		FO_IDLE,
		FO_REQ,
		FO_POP,
		FO_STROBE,
		FO_RELEASE
	} rtps_fo_state_t;

	// serial output sequencer; the second state frees the permit and trigger latches
	typedef enum logic [2:0] {
		SO_IDLE,
		SO_START,
		SO_LOAD,
		SO_HOLD,
		SO_GAP,
		SO_PASS
	} rtps_so_state_t;

endpackage : rtps_pkg

// >>> hw/rtps_sync.sv
`timescale 1ns/10ps

module rtps_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					stage1[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					stage1[i]   <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate

endmodule : rtps_sync

// >>> hw/rtps_fifo.sv
`timescale 1ns/10ps

module rtps_fifo #(
	parameter int WIDTH = 18,
	parameter int ABITS = 13
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// fill side
	input  wire logic             wr_valid,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  wr_ready,
	// drain side
	input  wire logic             rd_ready,
	output logic                  rd_valid,
	output logic      [WIDTH-1:0] rd_data,
	// fill level
	output logic      [ABITS:0]   level
);

	logic [WIDTH-1:0] mem [0:(1<<ABITS)-1];
	logic [ABITS-1:0] wr_ptr;
	logic [ABITS-1:0] rd_ptr;
	logic             do_push;
	logic             do_pop;

	assign wr_ready = (level != (ABITS+1)'(1 << ABITS));
	assign rd_valid = (level != '0);
	assign rd_data  = mem[rd_ptr];
	assign do_push  = wr_valid & wr_ready;
	assign do_pop   = rd_ready & rd_valid;

	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem[wr_ptr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			wr_ptr <= wr_ptr + ABITS'(do_push);
			rd_ptr <= rd_ptr + ABITS'(do_pop);
			level  <= level + (ABITS+1)'(do_push) - (ABITS+1)'(do_pop);
		end
	end

endmodule : rtps_fifo

// >>> hw/rtps_top.sv
`timescale 1ns/10ps
`include "rtps_cfg.svh"

//
// Contract
// - fifo word: data low 16, flags 17-18
// - written bits 19 to 24 ignored
// - readout fifo 18 bits by 8K
// - capture fifo 32 bits by 8K
// - capture read as two low-aligned halves
// - enabled readout mode raises request
// - enable answered by pop and strobe
// - after acknowledge drop strobe, next word
// - sequence ends on empty or pass flag
// - pass flag drops request, pulses pass
// - sink mode issues permit pulse
// - permit pulse lasts 150 to 250 ns
// - input strobe writes word into capture fifo
// - wait asserted from half full
// - raw mode slow data, still strobed
// - permits mode expects return after record end
// - output permit latched on falling edge
// - readout trigger latched, cleared in state 2
// - serial trigger latched, cleared in state 1
// - four level outputs follow control bits
// - event id driven from mode bits
// - mode bits 17-20 give id bits 0-3
// - busy mirrored into status only
module rtps_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// crate bus
	input  wire logic        camac_n,
	input  wire logic        camac_s1,
	input  wire logic [4:0]  camac_f,
	input  wire logic [3:0]  camac_a,
	input  wire logic [23:0] camac_w,
	output logic      [23:0] camac_r,
	output logic             camac_q,
	output logic             camac_x,
	// readout data port
	output logic             readout_request,
	input  wire logic        readout_enable,
	output logic      [15:0] word_data,
	output logic             word_write_strobe,
	input  wire logic        word_write_ack,
	output logic             token_pass_out,
	input  wire logic        readout_trigger_in,
	// capture input port
	input  wire logic [31:0] in_data,
	input  wire logic        in_strobe,
	input  wire logic        end_of_record,
	output logic             in_wait,
	output logic             input_permit_pulse_out,
	input  wire logic        input_permit_return,
	// serial output port
	output logic      [31:0] so_data,
	output logic             so_strobe,
	input  wire logic        so_wait_in,
	output logic             output_permit_pulse_out,
	input  wire logic        output_permit_return,
	input  wire logic        serial_out_trigger_in,
	// level outputs and monitors
	output logic             clear_out,
	output logic             gate_out,
	output logic             reset_out,
	output logic             end_of_event_out,
	output logic      [3:0]  event_id,
	input  wire logic        busy_in
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [`RTPS_SYNC_WIDTH-1:0] s_vec;
	logic        s_n, s_s1, s_ren, s_ack, s_stb, s_eor, s_ipr, s_opr, s_readout_trigger_in, s_serial_out_trigger_in;
	logic        s_busy, s_wait;
	logic [4:0]  s_f;
	logic [3:0]  s_a;
	logic [23:0] s_w;
	logic [31:0] s_d;

	rtps_sync #(.WIDTH(`RTPS_SYNC_WIDTH)) u_sync (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.async_in ({camac_n, camac_s1, camac_f, camac_a, camac_w, readout_enable,
		            word_write_ack, in_strobe, end_of_record, input_permit_return,
		            output_permit_return, readout_trigger_in, serial_out_trigger_in,
		            busy_in, so_wait_in, in_data}),
		.sync_out (s_vec)
	);

	assign {s_n, s_s1, s_f, s_a, s_w, s_ren, s_ack, s_stb, s_eor, s_ipr, s_opr,
	        s_readout_trigger_in, s_serial_out_trigger_in, s_busy, s_wait, s_d} = s_vec;

	// previous samples for edge detection
	logic p_s1, p_stb, p_eor, p_opr, p_readout_trigger_in, p_serial_out_trigger_in;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{p_s1, p_stb, p_eor, p_opr, p_readout_trigger_in, p_serial_out_trigger_in} <= 6'h00;
		end else begin
			{p_s1, p_stb, p_eor, p_opr, p_readout_trigger_in, p_serial_out_trigger_in} <=
				{s_s1, s_stb, s_eor, s_opr, s_readout_trigger_in, s_serial_out_trigger_in};
		end
	end

	wire cmd      = s_s1 & ~p_s1 & s_n;
	wire stb_rise = s_stb & ~p_stb;
	wire eor_rise = s_eor & ~p_eor;
	wire opr_fall = ~s_opr & p_opr;
	wire ft_rise  = s_readout_trigger_in & ~p_readout_trigger_in;
	wire rt_rise  = s_serial_out_trigger_in & ~p_serial_out_trigger_in;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic [23:0] mode;
	logic [3:0]  ctrl;
	wire  [3:0]  in_mode = mode[`RTPS_MODE_IN_LSB +: 4];
	wire  [3:0]  so_mode = mode[`RTPS_MODE_SO_LSB +: 4];
	wire  [3:0]  fo_mode = mode[`RTPS_MODE_FO_LSB +: 4];

	wire f_rfifo = (s_f == `RTPS_F_READ_FIFO);
	wire f_rreg  = (s_f == `RTPS_F_READ_REG);
	wire wr_fo   = cmd & (s_f == `RTPS_F_WRITE_FIFO) & (s_a == `RTPS_A_OUT_FIFO);
	wire wr_ctrl = cmd & (s_f == `RTPS_F_WRITE_REG) & (s_a == `RTPS_A_CTRL);
	wire wr_mode = cmd & (s_f == `RTPS_F_WRITE_REG) & (s_a == `RTPS_A_MODE);
	wire rd_lo   = f_rfifo & (s_a == `RTPS_A_CAP_LOW);
	wire rd_hi   = f_rfifo & (s_a == `RTPS_A_CAP_HIGH);
	wire rd_ctrl = f_rreg & (s_a == `RTPS_A_CTRL);
	wire rd_mode = f_rreg & (s_a == `RTPS_A_MODE);
	wire rd_stb  = f_rreg & (s_a == `RTPS_A_STATUS_B);
	wire rd_stin = f_rreg & (s_a == `RTPS_A_STATUS_IN);
	wire known   = wr_fo | wr_ctrl | wr_mode | rd_lo | rd_hi | rd_ctrl | rd_mode
	             | rd_stb | rd_stin;

	// ----------------------------------------------------------------
	// buffers
	// ----------------------------------------------------------------
	logic                     ff_ready, ff_valid, ff_pop;
	logic [`RTPS_FO_WIDTH-1:0] ff_data;
	logic [`RTPS_FO_ABITS:0]   ff_level;
	logic                     cf_ready, cf_valid, cf_pop, cf_push;
	logic [`RTPS_CF_WIDTH-1:0] cf_data;
	logic [`RTPS_CF_ABITS:0]   cf_level;
	logic                     so_pop;

	rtps_fifo #(.WIDTH(`RTPS_FO_WIDTH), .ABITS(`RTPS_FO_ABITS)) u_fo_fifo (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.wr_valid (wr_fo),
		.wr_data  (s_w[`RTPS_FO_WIDTH-1:0]),
		.wr_ready (ff_ready),
		.rd_ready (ff_pop),
		.rd_valid (ff_valid),
		.rd_data  (ff_data),
		.level    (ff_level)
	);

	rtps_fifo #(.WIDTH(`RTPS_CF_WIDTH), .ABITS(`RTPS_CF_ABITS)) u_cap_fifo (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.wr_valid (cf_push),
		.wr_data  (s_d),
		.wr_ready (cf_ready),
		.rd_ready (cf_pop),
		.rd_valid (cf_valid),
		.rd_data  (cf_data),
		.level    (cf_level)
	);

	// the crate drains the capture fifo only while the serial output mode is off
	assign cf_push = (in_mode != `RTPS_IN_OFF) & stb_rise;
	assign cf_pop  = (cmd & rd_hi & (so_mode == `RTPS_SO_OFF)) | so_pop;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic in_expect, in_token;
	wire [23:0] stat_b = {3'b000, 4'h0, 1'b0, 1'b0, s_busy, 8'h00,
	                      ff_ready, ff_level < `RTPS_FO_HALF, ff_valid,
	                      cf_ready, cf_level < `RTPS_CF_HALF, cf_valid};
	wire [23:0] next_r = rd_lo   ? {8'h00, cf_data[15:0]}  :
	                     rd_hi   ? {8'h00, cf_data[31:16]} :
	                     rd_ctrl ? {20'h00000, ctrl}       :
	                     rd_mode ? mode                    :
	                     rd_stb  ? stat_b                  :
	                     rd_stin ? {22'h000000, in_token, in_expect} : 24'h000000;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			camac_r <= 24'h000000;
			camac_q <= 1'b0;
			camac_x <= 1'b0;
		end else if (cmd) begin
			camac_r <= next_r;
			camac_q <= known & ~(wr_fo & ~ff_ready);
			camac_x <= known;
		end
	end

	// ----------------------------------------------------------------
	// mode, control and level outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= `RTPS_MODE_RESET;
			ctrl <= `RTPS_CTRL_RESET;
		end else begin
			if (wr_mode) mode <= s_w;
			if (wr_ctrl) ctrl <= s_w[3:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{end_of_event_out, reset_out, gate_out, clear_out} <= 4'h0;
			event_id <= 4'h0;
		end else begin
			{end_of_event_out, reset_out, gate_out, clear_out} <= ctrl;
			event_id <= mode[`RTPS_MODE_ID_LSB +: 4];
		end
	end

	// ----------------------------------------------------------------
	// readout sequencer
	// ----------------------------------------------------------------
	rtps_pkg::rtps_fo_state_t fo_state;
	logic readout_trigger_in_latch, last_pass;
	wire  fo_go = (fo_mode == `RTPS_FO_RUN) | ((fo_mode == `RTPS_FO_TRIG) & readout_trigger_in_latch);
	assign ff_pop = (fo_state == rtps_pkg::FO_POP);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			readout_trigger_in_latch <= 1'b0;
		end else if (ft_rise & (fo_mode == `RTPS_FO_TRIG)) begin
			readout_trigger_in_latch <= 1'b1;
		end else if (ff_pop | (fo_mode == `RTPS_FO_OFF)) begin
			readout_trigger_in_latch <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fo_state          <= rtps_pkg::FO_IDLE;
			readout_request   <= 1'b0;
			word_write_strobe <= 1'b0;
			word_data         <= 16'h0000;
			token_pass_out    <= 1'b0;
			last_pass         <= 1'b0;
		end else begin
			token_pass_out <= 1'b0;
			case (fo_state)
				rtps_pkg::FO_IDLE: begin
					if (fo_go & ff_valid) begin
						readout_request <= 1'b1;
						fo_state        <= rtps_pkg::FO_REQ;
					end
				end
				rtps_pkg::FO_REQ: begin
					if (fo_mode == `RTPS_FO_OFF) begin
						readout_request <= 1'b0;
						fo_state        <= rtps_pkg::FO_IDLE;
					end else if (s_ren) begin
						fo_state <= rtps_pkg::FO_POP;
					end
				end
				rtps_pkg::FO_POP: begin
					word_data         <= ff_data[15:0];
					last_pass         <= ff_data[`RTPS_FO_PASS_BIT];
					word_write_strobe <= 1'b1;
					if (ff_data[`RTPS_FO_PASS_BIT]) begin
						readout_request <= 1'b0;
						token_pass_out  <= 1'b1;
					end
					fo_state <= rtps_pkg::FO_STROBE;
				end
				rtps_pkg::FO_STROBE: begin
					if (s_ack) begin
						word_write_strobe <= 1'b0;
						fo_state          <= rtps_pkg::FO_RELEASE;
					end
				end
				rtps_pkg::FO_RELEASE: begin
					if (!s_ack) begin
						if (last_pass | ~ff_valid | (fo_mode == `RTPS_FO_OFF)) begin
							readout_request <= 1'b0;
							fo_state        <= rtps_pkg::FO_IDLE;
						end else begin
							fo_state <= rtps_pkg::FO_POP;
						end
					end
				end
				default: fo_state <= rtps_pkg::FO_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// capture port: permit pulse, wait, token status
	// ----------------------------------------------------------------
	logic [3:0] ip_cnt;
	wire  [3:0] next_ip_cnt = (wr_mode & (s_w[`RTPS_MODE_IN_LSB +: 4] != `RTPS_IN_OFF)) ?
	                          4'(`RTPS_PERMIT_CYC) : (ip_cnt != 4'h0) ? ip_cnt - 4'h1 : 4'h0;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ip_cnt                 <= 4'h0;
			input_permit_pulse_out <= 1'b0;
			in_wait                <= 1'b0;
			in_expect              <= 1'b0;
			in_token               <= 1'b0;
		end else begin
			ip_cnt                 <= next_ip_cnt;
			input_permit_pulse_out <= (next_ip_cnt != 4'h0);
			in_wait <= (in_mode != `RTPS_IN_OFF) & (cf_level >= `RTPS_CF_HALF);
			if (in_mode != `RTPS_IN_PERMITS) begin
				in_expect <= 1'b0;
			end else if (eor_rise) begin
				in_expect <= 1'b1;
				in_token  <= 1'b0;
			end else if (in_expect & s_ipr) begin
				in_expect <= 1'b0;
				in_token  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial output sequencer
	// ----------------------------------------------------------------
	rtps_pkg::rtps_so_state_t so_state;
	logic       opr_latch, serial_out_trigger_in_latch;
	logic [5:0] so_cnt;
	wire        so_raw  = (so_mode == `RTPS_SO_RAW);
	wire  [5:0] so_hold = so_raw ? 6'(`RTPS_RAW_CYC) : 6'(`RTPS_STRB_CYC);
	wire        so_go   = ((so_mode == `RTPS_SO_PERM) & opr_latch) | so_raw |
	                      ((so_mode == `RTPS_SO_TRIG) & serial_out_trigger_in_latch);
	wire        so_clr  = (so_state == rtps_pkg::SO_START) | (so_mode == `RTPS_SO_OFF);
	assign so_pop = (so_state == rtps_pkg::SO_LOAD) & (so_raw | ~s_wait) & cf_valid;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			opr_latch   <= 1'b0;
			serial_out_trigger_in_latch <= 1'b0;
		end else begin
			if (opr_fall) opr_latch <= 1'b1;
			else if (so_clr) opr_latch <= 1'b0;
			if (rt_rise & (so_mode == `RTPS_SO_TRIG)) serial_out_trigger_in_latch <= 1'b1;
			else if (so_clr) serial_out_trigger_in_latch <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			so_state                <= rtps_pkg::SO_IDLE;
			so_cnt                  <= 6'h00;
			so_data                 <= 32'h00000000;
			so_strobe               <= 1'b0;
			output_permit_pulse_out <= 1'b0;
		end else begin
			case (so_state)
				rtps_pkg::SO_IDLE: begin
					if (so_go & cf_valid) so_state <= rtps_pkg::SO_START;
				end
				rtps_pkg::SO_START: so_state <= rtps_pkg::SO_LOAD;
				rtps_pkg::SO_LOAD: begin
					if (!cf_valid | (so_mode == `RTPS_SO_OFF)) begin
						so_cnt                  <= 6'(`RTPS_PERMIT_CYC);
						output_permit_pulse_out <= 1'b1;
						so_state                <= rtps_pkg::SO_PASS;
					end else if (so_pop) begin
						so_data   <= cf_data;
						so_strobe <= 1'b1;
						so_cnt    <= so_hold;
						so_state  <= rtps_pkg::SO_HOLD;
					end
				end
				rtps_pkg::SO_HOLD: begin
					so_cnt <= so_cnt - 6'h01;
					if (so_cnt == 6'h01) begin
						so_strobe <= 1'b0;
						so_cnt    <= so_hold;
						so_state  <= rtps_pkg::SO_GAP;
					end
				end
				rtps_pkg::SO_GAP: begin
					so_cnt <= so_cnt - 6'h01;
					if (so_cnt == 6'h01) so_state <= rtps_pkg::SO_LOAD;
				end
				rtps_pkg::SO_PASS: begin
					so_cnt <= so_cnt - 6'h01;
					if (so_cnt == 6'h01) begin
						output_permit_pulse_out <= 1'b0;
						so_state                <= rtps_pkg::SO_IDLE;
					end
				end
				default: so_state <= rtps_pkg::SO_IDLE;
			endcase
		end
	end

endmodule : rtps_top

// >>> tb/rtps_top_assertions.sv
`timescale 1ns/10ps

// --------
// readout handshake and permit checks
// --------
module rtps_top_checker (
	// clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// readout port
	input wire logic        readout_request,
	input wire logic        readout_enable,
	input wire logic [15:0] word_data,
	input wire logic        word_write_strobe,
	input wire logic        word_write_ack,
	input wire logic        token_pass_out,
	// capture port
	input wire logic        input_permit_pulse_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_strobe_until_ack: assert property (word_write_strobe && !word_write_ack |=> word_write_strobe)
		else $error("write strobe dropped before acknowledge");
	chk_ack_ends_strobe: assert property ($rose(word_write_ack) |-> ##[1:5] !word_write_strobe)
		else $error("write strobe still high after acknowledge");
	chk_word_held: assert property (word_write_strobe && $past(word_write_strobe) |-> $stable(word_data))
		else $error("word changed under its strobe");
	chk_strobe_needs_enable: assert property ($rose(word_write_strobe) |-> readout_enable && $past(readout_request))
		else $error("strobe without request and enable");
	chk_pass_drops_request: assert property (token_pass_out |-> !readout_request)
		else $error("request still high at token pass");
	chk_pass_single: assert property (token_pass_out |=> !token_pass_out)
		else $error("token pass longer than one cycle");
	chk_pass_with_word: assert property (token_pass_out |-> $rose(word_write_strobe))
		else $error("token pass without its word");
	chk_permit_width: assert property ($rose(input_permit_pulse_out) |-> input_permit_pulse_out[*6] ##1 !input_permit_pulse_out)
		else $error("input permit pulse width wrong");
endmodule : rtps_top_checker

bind rtps_top rtps_top_checker u_rtps_top_checker (.mclk, .arst_n, .readout_request,
	.readout_enable, .word_data, .word_write_strobe, .word_write_ack, .token_pass_out,
	.input_permit_pulse_out);

// >>> tb/rtps_ctrl_model.sv
`timescale 1ns/10ps

// --------
// readout controller stand-in
// --------
module rtps_ctrl_model (
	// clock
	input wire logic       mclk,
	// handshake
	input wire logic       readout_request,
	input wire logic       word_write_strobe,
	output logic           readout_enable,
	output logic           word_write_ack,
	// extra cycles before each acknowledge
	input wire logic [3:0] ack_lag
);
	int held = 0;

	initial begin
		readout_enable = 1'b0;
		word_write_ack = 1'b0;
	end

	// enable stays up while a word is in flight after the request drops
	always @(posedge mclk) begin
		#2;
		readout_enable = readout_request | (readout_enable & (word_write_strobe | word_write_ack));
		held = word_write_strobe ? held + 1 : 0;
		word_write_ack = word_write_strobe & (held > ack_lag);
	end
endmodule : rtps_ctrl_model

// >>> tb/rtps_top_tb_top.sv
`timescale 1ns/10ps
`include "rtps_cfg.svh"

module rtps_top_tb_top;
	logic        mclk = 1'b0, arst_n = 1'b0, camac_n = 1'b0, camac_s1 = 1'b0;
	logic [4:0]  camac_f = 5'h00;
	logic [3:0]  camac_a = 4'h0, event_id, ack_lag = 4'h0;
	logic [23:0] camac_w = 24'h000000, camac_r;
	logic [31:0] in_data = 32'h00000000;
	logic [15:0] word_data;
	logic        in_strobe = 1'b0, busy_in = 1'b0, readout_trigger_in = 1'b0;
	logic        camac_q, camac_x, readout_request, readout_enable, word_write_strobe;
	logic        word_write_ack, token_pass_out, in_wait, input_permit_pulse_out;
	logic        clear_out, gate_out, reset_out, end_of_event_out, was_strobe = 1'b0;
	logic        was_permit = 1'b0;
	logic        end_of_record = 1'b0, input_permit_return = 1'b0;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	int          n_errors = 0, n_compared = 0, n_permit = 0;

	always #12.5 mclk = ~mclk;

	rtps_top u_rtps_top (.mclk, .arst_n, .camac_n, .camac_s1, .camac_f, .camac_a, .camac_w,
		.camac_r, .camac_q, .camac_x, .readout_request, .readout_enable, .word_data,
		.word_write_strobe, .word_write_ack, .token_pass_out, .readout_trigger_in, .in_data,
		.in_strobe, .end_of_record, .in_wait, .input_permit_pulse_out,
		.input_permit_return, .so_data(), .so_strobe(), .so_wait_in(1'b0),
		.output_permit_pulse_out(), .output_permit_return(1'b0), .serial_out_trigger_in(1'b0),
		.clear_out, .gate_out, .reset_out, .end_of_event_out, .event_id, .busy_in);

	rtps_ctrl_model u_rtps_ctrl_model (.mclk, .readout_request, .word_write_strobe,
		.readout_enable, .word_write_ack, .ack_lag);

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	// every pin change lands 2 ns after an edge, never on one
	task automatic cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w);
		@(posedge mclk);
		#2 camac_n = 1'b1;
		camac_f = f;
		camac_a = a;
		camac_w = w;
		@(posedge mclk);
		#2 camac_s1 = 1'b1;
		repeat (6) @(posedge mclk);
		#2 camac_s1 = 1'b0;
		camac_n = 1'b0;
		repeat (3) @(posedge mclk);
		#2;
	endtask : cmd

	task automatic push(input logic [31:0] d);
		@(posedge mclk);
		#2 in_data = d;
		repeat (4) @(posedge mclk);
		#2 in_strobe = 1'b1;
		repeat (4) @(posedge mclk);
		#2 in_strobe = 1'b0;
	endtask : push

	// --------
	// model of the word stream
	// --------
	always @(posedge mclk) begin
		if (word_write_strobe === 1'b1 && !was_strobe) begin
			if (exp_q.size() == 0)
				check("spare word", 32'h0, 32'h1);
			else begin
				e = exp_q.pop_front();
				check("word", 32'(e[15:0]), 32'(word_data));
				check("token pass", 32'(e[16]), 32'(token_pass_out));
			end
		end
		was_strobe = (word_write_strobe === 1'b1);
		if (input_permit_pulse_out === 1'b1 && !was_permit)
			n_permit++;
		was_permit = (input_permit_pulse_out === 1'b1);
	end

	task automatic readout_run(input logic [3:0] mode, input int n, input int gap);
		logic [23:0] w;
		int k;
		ack_lag = 4'($urandom_range(0, 9));
		for (int i = 0; i < n; i++) begin
			w = 24'($urandom);
			w[16] = (i % gap == gap - 1);
			exp_q.push_back(w[16:0]);
			cmd(`RTPS_F_WRITE_FIFO, `RTPS_A_OUT_FIFO, w);
		end
		cmd(`RTPS_F_WRITE_REG, `RTPS_A_MODE, {12'h0, mode, 8'h0});
		if (mode == `RTPS_FO_TRIG) begin
			repeat (20) @(posedge mclk);
			#2 check("request before trigger", 32'h0, 32'(readout_request));
			readout_trigger_in = 1'b1;
			#200 readout_trigger_in = 1'b0;
		end
		k = 0;
		while ((exp_q.size() != 0 || readout_request !== 1'b0) && k < 20000) begin
			@(posedge mclk);
			k++;
		end
		if (k == 20000) begin
			check("readout drained", 32'h1, 32'h0);
			give_verdict();
		end
		#2 cmd(`RTPS_F_WRITE_REG, `RTPS_A_MODE, 24'h0);
		$display("readout run done");
	endtask : readout_run

	initial begin
		logic [31:0] v;
		void'($urandom(13591));
		repeat (6) @(posedge mclk);
		#2 arst_n = 1'b1;
		check("request after reset", 32'h0, 32'(readout_request));
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			busy_in = v[4];
			cmd(`RTPS_F_WRITE_REG, `RTPS_A_CTRL, {20'h0, v[3:0]});
			check("levels", 32'(v[3:0]), 32'({end_of_event_out, reset_out, gate_out, clear_out}));
			cmd(`RTPS_F_WRITE_REG, `RTPS_A_MODE, {4'h0, v[8:5], 16'h0});
			check("event id", 32'(v[8:5]), 32'(event_id));
			cmd(`RTPS_F_READ_REG, `RTPS_A_STATUS_B, 24'h0);
			check("busy status", 32'(v[4]), 32'(camac_r[14]));
		end
		cmd(5'h1f, 4'hf, 24'h0);
		check("refused code", 32'h0, 32'({camac_q, camac_x}));
		$display("level test done");
		readout_run(`RTPS_FO_RUN, 14, 4);
		readout_run(`RTPS_FO_TRIG, 5, 5);
		cmd(`RTPS_F_WRITE_REG, `RTPS_A_MODE, 24'h000001);
		repeat (10) @(posedge mclk);
		check("permit pulses", 32'h1, 32'(n_permit));
		cmd(`RTPS_F_WRITE_REG, `RTPS_A_MODE, 24'h000002);
		end_of_record = 1'b1;
		cmd(`RTPS_F_READ_REG, `RTPS_A_STATUS_IN, 24'h0);
		check("return expected", 32'h1, 32'(camac_r));
		input_permit_return = 1'b1;
		cmd(`RTPS_F_READ_REG, `RTPS_A_STATUS_IN, 24'h0);
		check("token passed", 32'h2, 32'(camac_r));
		end_of_record = 1'b0;
		input_permit_return = 1'b0;
		for (int i = 0; i < 3; i++) begin
			v = $urandom;
			push(v);
			repeat (4) @(posedge mclk);
			cmd(`RTPS_F_READ_FIFO, `RTPS_A_CAP_LOW, 24'h0);
			check("capture low", 32'(v[15:0]), 32'(camac_r));
			cmd(`RTPS_F_READ_FIFO, `RTPS_A_CAP_HIGH, 24'h0);
			check("capture high", 32'(v[31:16]), 32'(camac_r));
		end
		for (int i = 0; i < 4095; i++)
			push($urandom);
		#2 check("wait below half", 32'h0, 32'(in_wait));
		push($urandom);
		repeat (6) @(posedge mclk);
		#2 check("wait at half", 32'h1, 32'(in_wait));
		arst_n = 1'b0;
		repeat (3) @(posedge mclk);
		check("wait in reset", 32'h0, 32'(in_wait));
		$display("capture test done");
		give_verdict();
	end
endmodule : rtps_top_tb_top
